// ===== hdl/cur_scaler.sv
// Purpose: clamp and linearly scale the source into a loop current
// Assumes: configuration is static while in use
// Notes:   divide is combinational; fine for slow set-points
`timescale 1ns/1ps
module cur_scaler (
    input  wire logic             i_clk_sys,
    input  wire logic             i_rst_n,
    input  wire out_pkg::chan_t   i_src,
    input  wire out_pkg::cur_cfg_t i_cfg,
    output logic [out_pkg::CUR_W-1:0] o_current
);
    import out_pkg::*;

    logic signed [VAL_W-1:0] clamped;
    logic signed [VAL_W:0]   span_in;
    logic signed [VAL_W:0]   offs;
    logic signed [CUR_W+1:0] span_out;
    logic signed [VAL_W+CUR_W+3:0] prod;
    logic signed [VAL_W+CUR_W+3:0] quot;
    logic signed [VAL_W+CUR_W+3:0] raw;
    logic [CUR_W-1:0] scaled;
    logic [CUR_W-1:0] alarm_lim;
    logic [CUR_W-1:0] cur_reg;
    logic [CUR_W-1:0] cur_next;
    logic             alarm;

    assign alarm = i_src.err | i_src.source_under_range_flag
                 | i_src.source_over_range_flag;

    always_comb
    begin
        if (i_src.value < i_cfg.in_lower)
            clamped = i_cfg.in_lower;
        else if (i_src.value > i_cfg.in_upper)
            clamped = i_cfg.in_upper;
        else
            clamped = i_src.value;
        span_in  = (VAL_W+1)'(i_cfg.in_upper) - (VAL_W+1)'(i_cfg.in_lower);
        offs     = (VAL_W+1)'(clamped) - (VAL_W+1)'(i_cfg.in_lower);
        span_out = $signed({2'b00, i_cfg.out_upper})
                 - $signed({2'b00, i_cfg.out_lower});
        prod     = (VAL_W+CUR_W+4)'(offs) * (VAL_W+CUR_W+4)'(span_out);
        // zero input span would divide by zero: pin to lower output
        quot     = (span_in > 0) ? prod / (VAL_W+CUR_W+4)'(span_in) : '0;
        raw      = quot + (VAL_W+CUR_W+4)'($signed({1'b0, i_cfg.out_lower}));
        if (raw < 0)
            scaled = '0;
        else if (raw > (VAL_W+CUR_W+4)'(2**CUR_W - 1))
            scaled = '1;
        else
            scaled = raw[CUR_W-1:0];
        if (i_cfg.alarm_cur < CUR_FLOOR)
            alarm_lim = CUR_FLOOR;
        else if (i_cfg.alarm_cur > CUR_CEIL)
            alarm_lim = CUR_CEIL;
        else
            alarm_lim = i_cfg.alarm_cur;
        cur_next = alarm ? alarm_lim : scaled;
    end

    always_ff @(posedge i_clk_sys)
    begin
        if (!i_rst_n)
            cur_reg <= CUR_RST;
        else
            cur_reg <= cur_next;
    end

    assign o_current = cur_reg;
endmodule

// ===== hdl/out_pkg.sv
// Purpose: shared types and constants for the output timing block
// Assumes: one system clock at 100 MHz, values are signed fixed point
// Notes:   times are counted in 0.1 s ticks
package out_pkg;

    localparam int VAL_W      = 24;
    localparam int TIME_W     = 16;
    localparam int CH_W       = 6;
    localparam int NUM_CH     = 60;
    // output current in microamperes
    localparam int CUR_W      = 16;

    localparam int TICK_MS    = 100;
    localparam int CLK_MHZ    = 100;
    localparam int TICK_CYC   = TICK_MS * 1000 * CLK_MHZ;
    localparam logic [TIME_W-1:0] PERIOD_MIN  = 16'h0001;
    localparam logic [CUR_W-1:0]  CUR_FLOOR   = 16'h0bb8;
    localparam logic [CUR_W-1:0]  CUR_CEIL    = 16'h55f0;
    localparam logic [TIME_W-1:0] TIME_RST    = 16'h0000;
    localparam logic [CUR_W-1:0]  CUR_RST     = 16'h0000;

    typedef enum logic [2:0] {
        MODE_DISABLED = 3'b000,
        MODE_ABOVE    = 3'b001,
        MODE_BELOW    = 3'b010,
        MODE_INSIDE   = 3'b011,
        MODE_OUTSIDE  = 3'b100,
        MODE_PWM      = 3'b101
    } out_mode_t;

    typedef enum logic [2:0] {
        ALM_NO_CHANGE = 3'b000,
        ALM_IMM_OFF   = 3'b001,
        ALM_IMM_ON    = 3'b010,
        ALM_TIMED_OFF = 3'b011,
        ALM_TIMED_ON  = 3'b100
    } alarm_react_t;

    typedef struct packed {
        logic signed [VAL_W-1:0] value;
        logic                    err;
        logic                    source_under_range_flag;
        logic                    source_over_range_flag;
    } chan_t;

    typedef struct packed {
        out_mode_t               mode;
        alarm_react_t            alarm_react;
        logic signed [VAL_W-1:0] level;
        logic signed [VAL_W-1:0] lower;
        logic signed [VAL_W-1:0] upper;
        logic signed [VAL_W-1:0] alarm_level;
        logic [TIME_W-1:0]       on_delay;
        logic [TIME_W-1:0]       off_delay;
        logic [TIME_W-1:0]       min_on;
        logic [TIME_W-1:0]       min_off;
        logic [TIME_W-1:0]       period;
    } relay_cfg_t;

    typedef struct packed {
        logic signed [VAL_W-1:0] in_lower;
        logic signed [VAL_W-1:0] in_upper;
        logic [CUR_W-1:0]        out_lower;
        logic [CUR_W-1:0]        out_upper;
        logic [CUR_W-1:0]        alarm_cur;
    } cur_cfg_t;

endpackage

// ===== hdl/output_timing_pwm_scaler.sv
// Purpose: built-in output: relay timing, time-proportioned pulse and
//          loop-current set-point from a selected logical channel
// Assumes: channel values arrive on the system clock
// Notes on behaviour
// - turn-on waits the switch-on delay
// - turn-off waits the switch-off delay
// - two-state high lasts minimum on time
// - two-state low lasts minimum off time
// - pulse period repeats, below 0.1 s rejected
// - duty proportional between lower and upper
// - below lower level: output stays low
// - above upper level: output stays high
// - pulse high holds minimum on time
// - pulse low holds minimum off time
// - error, under or over range is alarm
// - pulse alarm uses alarm level duty
// - current output takes one selected channel
// - current input clamped to input levels
// - linear map, clamped to output range
// - current alarm value limited 3 to 22 mA
// - low is 0, high is 1
// - above, below, inside, outside comparisons
// - alarm reaction: none, immediate, or timed
`timescale 1ns/1ps
module output_timing_pwm_scaler #(
    parameter int TICK_CYCLES = out_pkg::TICK_CYC,
    parameter int CHANNELS    = out_pkg::NUM_CH
) (
    input  wire logic                          i_clk_sys,
    input  wire logic                          i_rst_n,
    input  wire out_pkg::chan_t [CHANNELS-1:0] i_channels,
    input  wire logic [out_pkg::CH_W-1:0]      i_relay_src_sel,
    input  wire logic [out_pkg::CH_W-1:0]      i_cur_src_sel,
    input  wire out_pkg::relay_cfg_t           i_relay_cfg,
    input  wire out_pkg::cur_cfg_t             i_cur_cfg,
    output logic                               o_relay,
    output logic                               o_period_rejected,
    output logic                               o_alarm,
    output logic [out_pkg::CUR_W-1:0]          o_current
);
    import out_pkg::*;

    function automatic chan_t pick(input chan_t [CHANNELS-1:0] chs,
                                   input logic [CH_W-1:0] sel);
        if (int'(sel) < CHANNELS)
            pick = chs[sel];
        else
            pick = '0;
    endfunction

    function automatic logic is_alarm(input chan_t c);
        is_alarm = c.err | c.source_under_range_flag
                 | c.source_over_range_flag;
    endfunction

    typedef struct packed {
        logic              out;
        logic              want;
        logic [TIME_W-1:0] dly_cnt;
        logic [TIME_W-1:0] hold_cnt;
        logic              first;
        logic [TIME_W-1:0] per_cnt;
        logic [TIME_W-1:0] high_time;
        logic              rejected;
        logic              alarm;
    } relay_st_t;

    relay_st_t st_reg;
    relay_st_t st_next;
    logic      tick;
    chan_t     src;
    chan_t     cur_src;
    logic      raw;
    logic      target;
    logic      alm;
    logic      held;
    logic signed [VAL_W-1:0]     duty_in;
    logic signed [VAL_W:0]       span;
    logic signed [VAL_W:0]       pos;
    logic signed [VAL_W+TIME_W+2:0] prod;
    logic [TIME_W-1:0]           high_t;
    logic [TIME_W-1:0]           per_eff;

    tick_gen #(
        .CYCLES (TICK_CYCLES)
    ) u_tick (
        .i_clk_sys (i_clk_sys),
        .i_rst_n   (i_rst_n),
        .o_tick    (tick)
    );

    assign cur_src = pick(i_channels, i_cur_src_sel);

    cur_scaler u_cur (
        .i_clk_sys (i_clk_sys),
        .i_rst_n   (i_rst_n),
        .i_src     (cur_src),
        .i_cfg     (i_cur_cfg),
        .o_current (o_current)
    );

    always_comb
    begin
        src = pick(i_channels, i_relay_src_sel);
        alm = is_alarm(src);
        unique case (i_relay_cfg.mode)
            MODE_ABOVE:   raw = src.value > i_relay_cfg.level;
            MODE_BELOW:   raw = src.value < i_relay_cfg.level;
            MODE_INSIDE:  raw = src.value >= i_relay_cfg.lower
                              && src.value <= i_relay_cfg.upper;
            MODE_OUTSIDE: raw = src.value < i_relay_cfg.lower
                              || src.value > i_relay_cfg.upper;
            default:      raw = 1'b0;
        endcase

        duty_in = alm ? i_relay_cfg.alarm_level : src.value;
        span = (VAL_W+1)'(i_relay_cfg.upper) - (VAL_W+1)'(i_relay_cfg.lower);
        pos  = (VAL_W+1)'(duty_in) - (VAL_W+1)'(i_relay_cfg.lower);
        per_eff = (i_relay_cfg.period < PERIOD_MIN) ? PERIOD_MIN
                                                    : i_relay_cfg.period;
        prod = (VAL_W+TIME_W+3)'(pos)
             * (VAL_W+TIME_W+3)'({1'b0, per_eff});
        if (duty_in < i_relay_cfg.lower)
            high_t = '0;
        else if (duty_in > i_relay_cfg.upper || span <= 0)
            high_t = per_eff;
        else
            high_t = TIME_W'(prod / (VAL_W+TIME_W+3)'(span));

        st_next = st_reg;
        st_next.alarm = alm;
        st_next.rejected = i_relay_cfg.mode == MODE_PWM
                        && i_relay_cfg.period < PERIOD_MIN;
        target = st_reg.out;
        held = 1'b0;

        if (i_relay_cfg.mode == MODE_PWM)
        begin
            if (tick)
            begin
                if (st_reg.per_cnt + 16'h0001 >= per_eff)
                begin
                    st_next.per_cnt = '0;
                    st_next.high_time = high_t;
                end
                else
                    st_next.per_cnt = st_reg.per_cnt + 16'h0001;
            end
            target = st_next.per_cnt < st_next.high_time;
        end
        else if (i_relay_cfg.mode == MODE_DISABLED)
            target = 1'b0;
        else if (alm)
        begin
            unique case (i_relay_cfg.alarm_react)
                ALM_NO_CHANGE: held = 1'b1;
                ALM_IMM_OFF:   st_next.out = 1'b0;
                ALM_IMM_ON:    st_next.out = 1'b1;
                ALM_TIMED_OFF: target = 1'b0;
                ALM_TIMED_ON:  target = 1'b1;
                default:       held = 1'b1;
            endcase
            if (i_relay_cfg.alarm_react == ALM_IMM_OFF
                || i_relay_cfg.alarm_react == ALM_IMM_ON)
                held = 1'b1;
        end
        else
        begin
            if (target != raw && st_reg.want != raw)
                st_next.dly_cnt = '0;
            else if (target != raw && tick && st_reg.dly_cnt != 16'hffff)
                st_next.dly_cnt = st_reg.dly_cnt + 16'h0001;
            st_next.want = raw;
            if (raw != st_reg.out)
            begin
                if ((raw && st_next.dly_cnt >= i_relay_cfg.on_delay)
                    || (!raw && st_next.dly_cnt >= i_relay_cfg.off_delay))
                    target = raw;
            end
        end
        if (alm && i_relay_cfg.mode != MODE_PWM
            && i_relay_cfg.alarm_react >= ALM_TIMED_OFF)
        begin
            if (tick && target != st_reg.out && st_reg.dly_cnt != 16'hffff)
                st_next.dly_cnt = st_reg.dly_cnt + 16'h0001;
            if ((target && st_next.dly_cnt < i_relay_cfg.on_delay)
                || (!target && st_next.dly_cnt < i_relay_cfg.off_delay))
                target = st_reg.out;
        end

        // minimum duration counter runs in ticks
        if (tick && st_reg.hold_cnt != 16'hffff)
            st_next.hold_cnt = st_reg.hold_cnt + 16'h0001;
        if (!held && i_relay_cfg.mode != MODE_DISABLED
            && target != st_reg.out)
        begin
            if (st_reg.first
                || (st_reg.out && st_reg.hold_cnt >= i_relay_cfg.min_on)
                || (!st_reg.out && st_reg.hold_cnt >= i_relay_cfg.min_off))
            begin
                st_next.out = target;
                st_next.hold_cnt = '0;
                st_next.dly_cnt = '0;
                st_next.first = 1'b0;
            end
        end
        else if (i_relay_cfg.mode == MODE_DISABLED)
            st_next.out = 1'b0;
        if (held && st_next.out != st_reg.out)
        begin
            st_next.hold_cnt = '0;
            st_next.first = 1'b0;
        end
    end

    always_ff @(posedge i_clk_sys)
    begin
        if (!i_rst_n)
        begin
            st_reg <= '0;
            st_reg.first <= 1'b1;
        end
        else
            st_reg <= st_next;
    end

    // low is 0, high is 1
    assign o_relay           = st_reg.out;
    assign o_period_rejected = st_reg.rejected;
    assign o_alarm           = st_reg.alarm;
endmodule

// ===== hdl/tick_gen.sv
// Purpose: one-cycle pulse every tenth of a second
// Assumes: free-running system clock
// Notes:   count is a parameter so simulation can shorten it
`timescale 1ns/1ps
module tick_gen #(
    parameter int CYCLES = out_pkg::TICK_CYC
) (
    input  wire logic i_clk_sys,
    input  wire logic i_rst_n,
    output logic      o_tick
);
    import out_pkg::*;

    typedef struct packed {
        logic [31:0] cnt;
        logic        tick;
    } tick_st_t;

    tick_st_t st_reg;
    tick_st_t st_next;

    always_comb
    begin
        st_next = st_reg;
        st_next.tick = 1'b0;
        if (st_reg.cnt >= 32'(CYCLES - 1))
        begin
            st_next.cnt  = 32'h0000_0000;
            st_next.tick = 1'b1;
        end
        else
        begin
            st_next.cnt = st_reg.cnt + 32'h0000_0001;
        end
    end

    always_ff @(posedge i_clk_sys)
    begin
        if (!i_rst_n)
            st_reg <= '0;
        else
            st_reg <= st_next;
    end

    assign o_tick = st_reg.tick;
endmodule

// ===== tb/load_model.sv
// Purpose: stand-in for the relay or solid-state switch load
// Assumes: load energised while drive is high
// Notes:   counts energised clocks and switchings until cleared
`timescale 1ns/1ps
module load_model (
    input  wire logic i_clk_sys,
    input  wire logic i_clear,
    input  wire logic i_drive,
    output int        o_switches,
    output int        o_hi_cycles
);
    logic last;

    always @(posedge i_clk_sys)
    begin
        last <= i_drive;
        if (i_clear)
        begin
            o_switches  <= 0;
            o_hi_cycles <= 0;
        end
        else
        begin
            o_hi_cycles <= o_hi_cycles + int'(i_drive === 1'b1);
            o_switches  <= o_switches + int'(i_drive !== last);
        end
    end
endmodule

// ===== tb/out_chk.sv
// Purpose: port-level properties of the output block
// Assumes: one clock domain, config static while checked
// Notes:   minimum-duration checks allow one tick of phase slack
`timescale 1ns/1ps
module out_chk
    import out_pkg::*;
#(
    parameter int TICK_CYCLES = 10,
    parameter int CHANNELS    = 4
) (
    input wire logic                          i_clk_sys,
    input wire logic                          i_rst_n,
    input wire out_pkg::chan_t [CHANNELS-1:0] i_channels,
    input wire logic [out_pkg::CH_W-1:0]      i_relay_src_sel,
    input wire logic [out_pkg::CH_W-1:0]      i_cur_src_sel,
    input wire out_pkg::relay_cfg_t           i_relay_cfg,
    input wire out_pkg::cur_cfg_t             i_cur_cfg,
    input wire logic                          o_relay,
    input wire logic                          o_period_rejected,
    input wire logic                          o_alarm,
    input wire logic [out_pkg::CUR_W-1:0]     o_current
);
    chan_t rs;
    chan_t cs;
    logic  ra, ca, rq, moved, calm;
    int    hi_len, lo_len, mon, moff;

    assign rs = (i_relay_src_sel < CHANNELS) ?
                i_channels[i_relay_src_sel] : '0;
    assign cs = (i_cur_src_sel < CHANNELS) ? i_channels[i_cur_src_sel] : '0;
    assign ra = rs.err | rs.source_under_range_flag | rs.source_over_range_flag;
    assign ca = cs.err | cs.source_under_range_flag | cs.source_over_range_flag;
    assign calm = !o_alarm && i_relay_cfg.mode != MODE_DISABLED;
    assign mon = int'(i_relay_cfg.min_on) * TICK_CYCLES - TICK_CYCLES;
    assign moff = int'(i_relay_cfg.min_off) * TICK_CYCLES - TICK_CYCLES;

    // lengths of the present output level, in clocks
    always_ff @(posedge i_clk_sys)
    begin
        rq <= o_relay;
        if (!i_rst_n)
        begin
            moved  <= 1'b0;
            hi_len <= 0;
            lo_len <= 0;
        end
        else
        begin
            moved  <= moved | (rq != o_relay);
            hi_len <= o_relay ? hi_len + 1 : 0;
            lo_len <= o_relay ? 0 : lo_len + 1;
        end
    end

    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_rst_n);

    a_reset_clear: assert property (
        !$past(i_rst_n) |-> !o_relay && !o_alarm && o_current == CUR_RST)
        else $error("outputs not cleared by reset");
    a_alarm_follows: assert property (
        $past(i_rst_n) |-> o_alarm == $past(ra))
        else $error("alarm flag does not follow source state");
    a_period_flag: assert property (
        $past(i_rst_n) |-> o_period_rejected ==
        ($past(i_relay_cfg.mode) == MODE_PWM &&
         $past(i_relay_cfg.period) < PERIOD_MIN))
        else $error("short period flag wrong");
    a_cur_alarm_lim: assert property (
        $past(i_rst_n) && $past(ca) |->
        o_current >= CUR_FLOOR && o_current <= CUR_CEIL)
        else $error("alarm current outside loop limits");
    a_cur_low_clamp: assert property (
        $past(i_rst_n) && !$past(ca) &&
        $past(cs.value) <= $past(i_cur_cfg.in_lower)
        |-> o_current == $past(i_cur_cfg.out_lower))
        else $error("low input not clamped to lower current");
    a_cur_high_clamp: assert property (
        $past(i_rst_n) && !$past(ca) &&
        $past(cs.value) >= $past(i_cur_cfg.in_upper)
        |-> o_current == $past(i_cur_cfg.out_upper))
        else $error("high input not clamped to upper current");
    a_min_on_hold: assert property (
        $fell(o_relay) && moved && calm && !$past(o_alarm) &&
        $stable(i_relay_cfg.mode) |-> hi_len >= mon)
        else $error("high level shorter than minimum");
    a_min_off_hold: assert property (
        $rose(o_relay) && moved && calm && !$past(o_alarm) &&
        $stable(i_relay_cfg.mode) |-> lo_len >= moff)
        else $error("low level shorter than minimum");

    c_pwm_rise: cover property (i_relay_cfg.mode == MODE_PWM && $rose(o_relay));
    c_cur_alarm: cover property (ca && o_current == CUR_FLOOR);
    c_rejected: cover property (o_period_rejected);
endmodule

bind output_timing_pwm_scaler out_chk #(
    .TICK_CYCLES(TICK_CYCLES),
    .CHANNELS(CHANNELS)
) u_chk (
    .i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_channels(i_channels),
    .i_relay_src_sel(i_relay_src_sel), .i_cur_src_sel(i_cur_src_sel),
    .i_relay_cfg(i_relay_cfg), .i_cur_cfg(i_cur_cfg), .o_relay(o_relay),
    .o_period_rejected(o_period_rejected), .o_alarm(o_alarm),
    .o_current(o_current)
);

// ===== tb/tb.sv
// Purpose: self-checking bench for the output timing block
// Assumes: tick shortened to 10 clocks, four channels
// Notes:   expected values come from the small functions, tables and literals below
`timescale 1ns/1ps
module tb;
    import out_pkg::*;
    localparam int TK = 10;

    logic            clk = 1'b0;
    logic            rst_n = 1'b0;
    logic            clr = 1'b1;
    chan_t [3:0]     ch = '0;
    logic [CH_W-1:0] rsel = 6'h01;
    logic [CH_W-1:0] csel = 6'h02;
    relay_cfg_t      rcfg = '{MODE_DISABLED, ALM_NO_CHANGE, 24'sh1f4,
        24'sh0c8, 24'sh320, 24'sh28a, 16'h0, 16'h0, 16'h0, 16'h0, 16'h4};
    cur_cfg_t        ccfg = '{24'sh0, 24'sh3e8, 16'h0fa0, 16'h4e20, 16'h0};
    logic            relay, rej, alm;
    logic [CUR_W-1:0] cur;
    int              sw, hic, v;
    int              fails = 0;
    int              tests_run = 0;
    logic [31:0]     seed = 32'h0000_1e8a;
    logic [15:0]     alc [3] = '{16'h03e8, 16'h7530, 16'h3039};
    alarm_react_t    rk [5] = '{ALM_IMM_ON, ALM_IMM_OFF, ALM_TIMED_ON,
                                ALM_TIMED_OFF, ALM_NO_CHANGE};
    int              rv [5] = '{0, 600, 0, 600, 600};
    logic [4:0]      e3 = 5'h19;
    logic [4:0]      e45 = 5'h15;
    int              pv [4] = '{-50, 900, 500, -50};
    int              ph [4] = '{0, 160, 80, 120};

    always #5 clk = ~clk;

    output_timing_pwm_scaler #(.TICK_CYCLES(TK), .CHANNELS(4)) dut (
        .i_clk_sys(clk), .i_rst_n(rst_n), .i_channels(ch),
        .i_relay_src_sel(rsel), .i_cur_src_sel(csel), .i_relay_cfg(rcfg),
        .i_cur_cfg(ccfg), .o_relay(relay), .o_period_rejected(rej),
        .o_alarm(alm), .o_current(cur));

    load_model u_load (.i_clk_sys(clk), .i_clear(clr), .i_drive(relay),
        .o_switches(sw), .o_hi_cycles(hic));

    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    function automatic int cur_exp(input int x, input bit al, input int ac);
        if (al)
            return ac < int'(CUR_FLOOR) ? int'(CUR_FLOOR) :
                   (ac > int'(CUR_CEIL) ? int'(CUR_CEIL) : ac);
        x = x < 0 ? 0 : (x > 1000 ? 1000 : x);
        return 4000 + x * 16;
    endfunction

    function automatic logic raw(input out_mode_t m, input int x);
        logic inr;
        inr = x >= rcfg.lower && x <= rcfg.upper;
        case (m)
            MODE_ABOVE: return x > rcfg.level;
            MODE_BELOW: return x < rcfg.level;
            MODE_INSIDE: return inr;
            default: return !inr;
        endcase
    endfunction

    task automatic w(input int n);
        repeat (n) @(posedge clk);
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        @(negedge clk);
        tests_run++;
        if (got !== exp)
        begin
            fails++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chk_rng(input int got, input int lo, input int hi);
        tests_run++;
        if (got < lo || got > hi)
        begin
            fails++;
            $display("CHECK FAILED t=%0t got=%h exp=%h..%h",
                     $time, got, lo, hi);
        end
    endtask

    task automatic cfg(input out_mode_t m, input alarm_react_t a,
                       input logic [15:0] dl, input logic [15:0] mn);
        @(posedge clk);
        rcfg.mode <= m;
        rcfg.alarm_react <= a;
        rcfg.on_delay <= dl;
        rcfg.off_delay <= dl + 16'h1;
        rcfg.min_on <= mn;
        rcfg.min_off <= mn;
    endtask

    task automatic setv(input int x);
        @(posedge clk);
        ch[1].value <= VAL_W'(x);
    endtask

    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    initial
    begin
        #100000;
        fails++;
        tally_and_finish();
    end

    initial
    begin
        for (int i = 0; i < 4; i++)
            ch[i].value <= VAL_W'(rnd() % 32'd1000);
        w(6);
        // outputs must read zero while reset is held
        chk({relay, alm, cur}, 0);
        w(1);
        rst_n <= 1'b1;
        w(1);
        rsel <= 6'h02;
        for (int i = 0; i < 12; i++)
        begin
            v = int'(rnd() % 32'd1400) - 200;
            w(1);
            ch[2].value <= VAL_W'(v);
            w(2);
            chk(cur, cur_exp(v, 0, 0));
        end
        for (int i = 0; i < 3; i++)
        begin
            w(1);
            {ch[2].err, ch[2].source_under_range_flag,
             ch[2].source_over_range_flag} <= 3'b100 >> i;
            ccfg.alarm_cur <= alc[i];
            w(2);
            chk(cur, cur_exp(0, 1, alc[i]));
            chk(alm, 1);
        end
        w(1);
        ch[2] <= '0;
        rsel <= 6'h01;
        $display("test current done");
        cfg(MODE_ABOVE, ALM_NO_CHANGE, 16'h2, 16'h0);
        setv(0);
        w(5 * TK);
        setv(600);
        w(TK);
        chk(relay, 0);
        w(4 * TK);
        chk(relay, 1);
        setv(100);
        w(2 * TK);
        chk(relay, 1);
        w(3 * TK);
        chk(relay, 0);
        $display("test delays done");
        for (int m = 1; m < 5; m++)
        begin
            cfg(out_mode_t'(m), ALM_NO_CHANGE, 16'h0, 16'h0);
            for (int i = 0; i < 6; i++)
            begin
                v = int'(rnd() % 32'd1000);
                setv(v);
                w(3 * TK);
                chk(relay, raw(out_mode_t'(m), v));
            end
        end
        $display("test modes done");
        cfg(MODE_ABOVE, ALM_NO_CHANGE, 16'h0, 16'h6);
        setv(0);
        w(8 * TK);
        setv(600);
        w(2 * TK);
        chk(relay, 1);
        setv(0);
        w(TK);
        chk(relay, 1);
        w(5 * TK);
        chk(relay, 0);
        setv(600);
        w(TK);
        chk(relay, 0);
        w(7 * TK);
        chk(relay, 1);
        $display("test minimum durations done");
        for (int i = 0; i < 5; i++)
        begin
            cfg(MODE_ABOVE, rk[i], 16'h2, 16'h0);
            setv(rv[i]);
            w(5 * TK);
            ch[1].err <= 1'b1;
            w(3);
            chk(relay, e3[i]);
            chk(alm, 1);
            w(45);
            chk(relay, e45[i]);
            w(1);
            ch[1].err <= 1'b0;
        end
        $display("test alarm reactions done");
        cfg(MODE_PWM, ALM_NO_CHANGE, 16'h0, 16'h0);
        for (int i = 0; i < 4; i++)
        begin
            setv(pv[i]);
            ch[1].err <= (i == 3);
            w(80);
            clr <= 1'b1;
            w(1);
            clr <= 1'b0;
            w(160);
            v = (ph[i] == 0 || ph[i] == 160) ? 1 : 12;
            chk_rng(hic, ph[i] - v, ph[i] + v);
            if (i == 2)
                chk_rng(sw, 7, 9);
        end
        w(1);
        ch[1].err <= 1'b0;
        rcfg.period <= 16'h0;
        w(3);
        chk(rej, 1);
        w(1);
        rcfg.period <= 16'h4;
        w(3);
        chk(rej, 0);
        $display("test pulse mode done");
        tally_and_finish();
    end
endmodule
